// ==== tcap_cfg_mem.sv ====
// Configuration word store with a registered read port.
`timescale 1ns/100ps
module tcap_cfg_mem
   import tcap_pkg::*;
#(
   parameter int ADDR_W = CFG_ADDR_W,
   parameter int DATA_W = CFG_DATA_W,
   parameter int DEPTH = CFG_DEPTH
)
(
   input wire logic core_clk, // Access clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic memEn, // Access strobe for one cycle.
   input wire logic memWe, // High writes, low reads.
   input wire logic [ADDR_W-1:0] memAddr, // Word address.
   input wire logic [DATA_W-1:0] memWdata, // Word to store.
   output logic [DATA_W-1:0] memRdata // Registered read word.
);

   logic [DATA_W-1:0] store [DEPTH];
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   // Array write; the array itself needs no reset.
   always_ff @(posedge core_clk)
   begin
      if (memEn && memWe)
      begin
         store[memAddr] <= memWdata;
      end
   end

   // A read updates the output word; a write leaves it standing.
   always_comb
   begin
      rdata_next = rdata_reg;
      if (memEn && !memWe)
      begin
         rdata_next = store[memAddr];
      end
   end

   // Read register.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_reg <= DATA_W'(READ_WORD_RESET);
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign memRdata = rdata_reg;

endmodule

// ==== tcap_ctrl_model.sv ====
// Controller model that posts one transfer at a time on the access port.
`timescale 1ns/100ps
module tcap_ctrl_model
   import tcap_pkg::*;
(
   input wire logic core_clk, // Access clock.
   output logic strobe, // Transfer strobe.
   output logic writeSel, // High write, low read.
   output logic [CFG_ADDR_W-1:0] addr, // Word address.
   output logic [CFG_DATA_W-1:0] wdata, // Word to write.
   input wire logic [CFG_DATA_W-1:0] rdata, // Word read back.
   input wire logic done, // Completion pulse.
   input wire logic occupied // Transfer in progress.
);
   // Lines start idle with no transfer requested.
   initial
   begin
      strobe = 1'b0;
      writeSel = 1'b1;
      addr = 9'h1AA;
      wdata = 16'hA5A5;
   end

   // Posts one transfer from a falling edge; an extra strobe may be pushed into the busy window.
   // Released address and data lines carry the inverse so stale values never look valid.
   task automatic xfer(input logic we, input logic [CFG_ADDR_W-1:0] a,
      input logic [CFG_DATA_W-1:0] d, input bit extra, output logic [CFG_DATA_W-1:0] q,
      output int lat, output logic occSeen);
      lat = 0;
      occSeen = 1'b0;
      while (occupied !== 1'b0 && lat < 20)
      begin
         @(negedge core_clk);
         lat++;
      end
      lat = 0;
      strobe = 1'b1;
      writeSel = we;
      addr = a;
      wdata = d;
      while (lat < 20)
      begin
         @(posedge core_clk);
         #1;
         lat++;
         if (done === 1'b1)
            break;
         @(negedge core_clk);
         if (lat == 1)
         begin
            occSeen = occupied;
            strobe = extra;
            writeSel = 1'b1;
            addr = ~a;
            wdata = ~d;
         end
         else
            strobe = 1'b0;
      end
      q = rdata;
      @(negedge core_clk);
   endtask
endmodule

// ==== tcap_pkg.sv ====
// Shared constants and types for the transceiver configuration access port.
package tcap_pkg;

   // -----------------------------------------------------------------
   // Widths and timing
   // -----------------------------------------------------------------
   localparam int CFG_ADDR_W = 9;
   localparam int CFG_DATA_W = 16;
   localparam int CFG_DEPTH = 512;
   localparam int ACCESS_WAIT_CYCLES = 2;
   localparam int RESET_DONE_CYCLES = 16;
   localparam int CLK_DIV_RATIO = 4;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] XCVR_CTRL_DEFAULT = 16'h0000;
   localparam logic [15:0] READ_WORD_RESET = 16'h0000;
   localparam logic [1:0] DIV_CNT_RESET = 2'h0;

   // -----------------------------------------------------------------
   // Access sequencer states, Gray coded along the path
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      TCAP_IDLE = 2'b00,
      TCAP_WAIT = 2'b01,
      TCAP_FETCH = 2'b11,
      TCAP_FINISH = 2'b10
   } tcap_state_e;

endpackage

// ==== tcap_tb.sv ====
// Self-checking bench for the configuration access port and shared outputs.
`timescale 1ns/100ps
module tb
   import tcap_pkg::*;
;
   logic core_clk, rst, strobe, writeSel, done, occ, hrIn, csIn, hrOut, csOut, rstDone, quarter;
   logic done2, occ2, quarter2, occSeen;
   logic done2Seen = 1'b0;
   logic [CFG_ADDR_W-1:0] addr;
   logic [CFG_DATA_W-1:0] wdata, rdata, ctrlWord, rdata2, ctrl2, q;
   logic [3:0] qv;
   int bad_count = 0, tests_run = 0, cycles = 0, lat;
   localparam int DONE_N = 4;
   localparam logic ROW_WE [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   localparam logic [8:0] ROW_A [6] = '{9'h000, 9'h1FF, 9'h0A5, 9'h0A5, 9'h1FF, 9'h000};
   localparam logic [15:0] ROW_D [6] = '{16'h1234, 16'hFFFF, 16'h0001, 16'h0, 16'h0, 16'h0};
   localparam logic [15:0] ROW_Q [6] = '{16'h0, 16'h0, 16'h0, 16'h0001, 16'hFFFF, 16'h1234};

   // ---------------------------------------------------------------
   // Devices: enabled port, and a disabled port on the newer family
   // ---------------------------------------------------------------
   tcap_top #(.DONE_CYCLES(DONE_N)) tcap_top_i (.core_clk(core_clk), .rst(rst),
      .cfg_access_strobe_flag(strobe), .cfg_write_select(writeSel), .cfg_access_address(addr),
      .cfg_write_word(wdata), .cfg_read_word(rdata), .cfg_access_done(done),
      .cfg_access_occupied(occ), .xcvrCtrlWord(ctrlWord), .hardResetIn(hrIn),
      .clockStableIn(csIn), .hardResetOut(hrOut), .clockStableOut(csOut),
      .resetDone(rstDone), .stable_clock_quarter_out(quarter));
   tcap_top #(.CTRL_PORTS_EN(1'b0), .NEWER_FAMILY(1'b1), .DONE_CYCLES(DONE_N)) tcap_top_i2 (
      .core_clk(core_clk), .rst(rst), .cfg_access_strobe_flag(strobe),
      .cfg_write_select(writeSel), .cfg_access_address(addr), .cfg_write_word(wdata),
      .cfg_read_word(rdata2), .cfg_access_done(done2), .cfg_access_occupied(occ2),
      .xcvrCtrlWord(ctrl2), .hardResetIn(hrIn), .clockStableIn(csIn), .hardResetOut(),
      .clockStableOut(), .resetDone(), .stable_clock_quarter_out(quarter2));
   tcap_ctrl_model tcap_ctrl_model_i (.core_clk(core_clk), .strobe(strobe),
      .writeSel(writeSel), .addr(addr), .wdata(wdata), .rdata(rdata), .done(done),
      .occupied(occ));

   // Compares a seen value with the expected one and counts both.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Clock generator at 40 ns.
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Cuts a hang short and remembers any activity of the disabled port, away from the edge.
   always @(negedge core_clk)
   begin
      cycles++;
      if (done2 === 1'b1 || occ2 === 1'b1)
         done2Seen <= 1'b1;
      if (cycles == 3000)
      begin
         bad_count++;
         summarize();
      end
   end

   // Main sequence: reset, table of transfers, then the awkward cases.
   initial
   begin
      rst = 1'b1;
      hrIn = 1'b1;
      csIn = 1'b0;
      repeat (8) @(negedge core_clk);
      chk({rdata, ctrlWord}, 32'h0000_0000);
      chk({done, occ, hrOut, csOut, rstDone, quarter}, 6'h08);
      rst = 1'b0;
      hrIn = 1'b0;
      csIn = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk({hrOut, csOut, rstDone}, 3'h2);
      repeat (DONE_N - 1) @(posedge core_clk);
      #1 chk(rstDone, 1'b0);
      @(posedge core_clk);
      #1 chk(rstDone, 1'b1);
      @(negedge core_clk);
      for (int i = 0; i < 6; i++)
      begin
         tcap_ctrl_model_i.xfer(ROW_WE[i], ROW_A[i], ROW_D[i], 1'b0, q, lat, occSeen);
         chk(q, ROW_Q[i]);
         chk(lat, ACCESS_WAIT_CYCLES + 2);
         chk(occSeen, 1'b1);
      end
      chk(ctrlWord, 16'h1234);
      tcap_ctrl_model_i.xfer(1'b0, 9'h1FF, 16'h5A5A, 1'b1, q, lat, occSeen);
      chk(q, 16'hFFFF);
      chk(lat, ACCESS_WAIT_CYCLES + 2);
      tcap_ctrl_model_i.xfer(1'b0, 9'h000, 16'h0000, 1'b0, q, lat, occSeen);
      chk({q, ctrlWord}, {2{16'h1234}});
      hrIn = 1'b1;
      csIn = 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chk({hrOut, csOut, rstDone}, 3'h4);
      for (int k = 0; k < 8; k++)
      begin
         @(posedge core_clk);
         #1 chk(quarter, 1'b0);
         if (k < 4)
            qv[k] = quarter2;
         else
            chk(quarter2, qv[k-4]);
      end
      chk(qv == 4'h3 || qv == 4'h6 || qv == 4'hC || qv == 4'h9, 1'b1);
      // Mid-run reset: outputs fall back at once, and the first transfer after it runs.
      @(negedge core_clk);
      rst = 1'b1;
      #1 chk({rdata, ctrlWord}, 32'h0000_0000);
      chk({done, occ, hrOut, rstDone}, 4'h2);
      @(negedge core_clk);
      rst = 1'b0;
      tcap_ctrl_model_i.xfer(1'b0, 9'h0A5, 16'h0000, 1'b0, q, lat, occSeen);
      chk(lat, ACCESS_WAIT_CYCLES + 2);
      chk(occSeen, 1'b1);
      chk(done2Seen, 1'b0);
      chk({rdata2, ctrl2}, 32'h0000_0000);
      summarize();
   end
endmodule

// ==== tcap_top.sv ====
// Transceiver configuration access port with shared clock and reset outputs.
//
// Contract
// - Device returns addressed word on read.
// - Done marks write complete or data valid.
// - Occupied flag high while access in progress.
// - Access port exists only when enabled.
// - Disabled controls tie to default values.
// - Reset done follows completed reset sequence.
// - Hard reset output synchronised to clock.
// - Quarter clock only newer family, ports off.
// - Forward synchronised clock-stable indication.
`timescale 1ns/100ps
module tcap_top
   import tcap_pkg::*;
#(
   parameter bit CTRL_PORTS_EN = 1'b1,
   parameter bit BUSY_FLAG_EN = 1'b1,
   parameter bit NEWER_FAMILY = 1'b0,
   parameter int WAIT_CYCLES = ACCESS_WAIT_CYCLES,
   parameter int DONE_CYCLES = RESET_DONE_CYCLES
)
(
   input wire logic core_clk, // Access clock and stable clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic cfg_access_strobe_flag, // Starts one transfer.
   input wire logic cfg_write_select, // High write, low read.
   input wire logic [CFG_ADDR_W-1:0] cfg_access_address, // Word address.
   input wire logic [CFG_DATA_W-1:0] cfg_write_word, // Word to write.
   output logic [CFG_DATA_W-1:0] cfg_read_word, // Word read back.
   output logic cfg_access_done, // One-cycle completion pulse.
   output logic cfg_access_occupied, // Transfer in progress.
   output logic [CFG_DATA_W-1:0] xcvrCtrlWord, // Control word at address 0.
   input wire logic hardResetIn, // Raw hard reset request.
   input wire logic clockStableIn, // Clock generator lock.
   output logic hardResetOut, // Synchronised hard reset.
   output logic clockStableOut, // Synchronised lock.
   output logic resetDone, // Reset sequence complete.
   output logic stable_clock_quarter_out // Clock divided by four on the newer family with ports off, else low.
);

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   tcap_state_e state_reg;
   tcap_state_e state_next;
   logic [7:0] waitCnt_reg;
   logic [7:0] waitCnt_next;
   logic we_reg;
   logic we_next;
   logic [CFG_ADDR_W-1:0] addr_reg;
   logic [CFG_ADDR_W-1:0] addr_next;
   logic [CFG_DATA_W-1:0] wdata_reg;
   logic [CFG_DATA_W-1:0] wdata_next;
   logic [CFG_DATA_W-1:0] ctrl_reg;
   logic [CFG_DATA_W-1:0] ctrl_next;
   logic [CFG_DATA_W-1:0] memRdata;
   logic memEn;
   logic takeReq;

   // A strobe is taken only when idle; strobes during a transfer are dropped.
   assign takeReq = CTRL_PORTS_EN && cfg_access_strobe_flag && (state_reg == TCAP_IDLE);
   assign memEn = (state_reg == TCAP_FETCH);

   // Next-state logic of the sequencer and the captured request.
   always_comb
   begin
      state_next = state_reg;
      waitCnt_next = waitCnt_reg;
      we_next = we_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      ctrl_next = ctrl_reg;
      case (state_reg)
         TCAP_IDLE:
         begin
            if (takeReq)
            begin
               we_next = cfg_write_select;
               addr_next = cfg_access_address;
               wdata_next = cfg_write_word;
               waitCnt_next = 8'(WAIT_CYCLES - 1);
               state_next = TCAP_WAIT;
            end
         end
         TCAP_WAIT:
         begin
            if (waitCnt_reg == 8'h00)
            begin
               state_next = TCAP_FETCH;
            end
            else
            begin
               waitCnt_next = waitCnt_reg - 8'h01;
            end
         end
         TCAP_FETCH:
         begin
            if (we_reg && (addr_reg == '0))
            begin
               ctrl_next = wdata_reg;
            end
            state_next = TCAP_FINISH;
         end
         TCAP_FINISH:
         begin
            state_next = TCAP_IDLE;
         end
         default:
         begin
            state_next = TCAP_IDLE;
         end
      endcase
   end

   // Sequencer registers, all on the access clock.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= TCAP_IDLE;
         waitCnt_reg <= 8'h00;
         we_reg <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         ctrl_reg <= XCVR_CTRL_DEFAULT;
      end
      else
      begin
         state_reg <= state_next;
         waitCnt_reg <= waitCnt_next;
         we_reg <= we_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Configuration word store.
   tcap_cfg_mem #(
      .ADDR_W(CFG_ADDR_W),
      .DATA_W(CFG_DATA_W),
      .DEPTH(CFG_DEPTH)
   ) u_mem (
      .core_clk(core_clk),
      .rst(rst),
      .memEn(memEn),
      .memWe(we_reg),
      .memAddr(addr_reg),
      .memWdata(wdata_reg),
      .memRdata(memRdata)
   );

   // Port outputs; a disabled port shows defaults only.
   assign cfg_read_word = CTRL_PORTS_EN ? memRdata : READ_WORD_RESET;
   assign cfg_access_done = (state_reg == TCAP_FINISH);
   assign cfg_access_occupied = BUSY_FLAG_EN && (state_reg != TCAP_IDLE);
   assign xcvrCtrlWord = CTRL_PORTS_EN ? ctrl_reg : XCVR_CTRL_DEFAULT;

   // ----------------------------------------------------------------
   // Shared clock and reset outputs
   // ----------------------------------------------------------------
   logic [1:0] rstSync_reg;
   logic [1:0] rstSync_next;
   logic [1:0] lockSync_reg;
   logic [1:0] lockSync_next;
   logic [7:0] doneCnt_reg;
   logic [7:0] doneCnt_next;
   logic resetDone_reg;
   logic resetDone_next;
   logic [1:0] div_reg;
   logic [1:0] div_next;

   // Synchronisers, reset-done timer and the divide-by-four counter.
   always_comb
   begin
      rstSync_next = {rstSync_reg[0], hardResetIn};
      lockSync_next = {lockSync_reg[0], clockStableIn};
      div_next = div_reg + 2'h1;
      doneCnt_next = doneCnt_reg;
      resetDone_next = resetDone_reg;
      if (rstSync_reg[1] || !lockSync_reg[1])
      begin
         doneCnt_next = 8'h00;
         resetDone_next = 1'b0;
      end
      else if (doneCnt_reg == 8'(DONE_CYCLES - 1))
      begin
         resetDone_next = 1'b1;
      end
      else
      begin
         doneCnt_next = doneCnt_reg + 8'h01;
      end
   end

   // Registers of the shared outputs.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rstSync_reg <= 2'b11;
         lockSync_reg <= 2'b00;
         doneCnt_reg <= 8'h00;
         resetDone_reg <= 1'b0;
         div_reg <= DIV_CNT_RESET;
      end
      else
      begin
         rstSync_reg <= rstSync_next;
         lockSync_reg <= lockSync_next;
         doneCnt_reg <= doneCnt_next;
         resetDone_reg <= resetDone_next;
         div_reg <= div_next;
      end
   end

   assign hardResetOut = rstSync_reg[1];
   assign clockStableOut = lockSync_reg[1];
   assign resetDone = resetDone_reg;
   assign stable_clock_quarter_out = (NEWER_FAMILY && !CTRL_PORTS_EN) ? div_reg[1] : 1'b0;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence sReadReq;
      takeReq && !cfg_write_select;
   endsequence

   AST_DONE_LATENCY: assert property (takeReq |-> ##(WAIT_CYCLES + 2) cfg_access_done)
      else $error("done not seen at fixed latency");
   AST_DONE_PULSE: assert property (cfg_access_done |=> !cfg_access_done)
      else $error("done longer than one cycle");
   AST_BUSY_SPAN: assert property (takeReq |=> cfg_access_occupied == BUSY_FLAG_EN)
      else $error("occupied flag missing during transfer");
   AST_BUSY_IDLE: assert property ($fell(cfg_access_occupied) |-> $past(cfg_access_done))
      else $error("occupied dropped before done");
   // The read word may only move in the done cycle of a read.
   AST_READ_STABLE: assert property ($changed(cfg_read_word) |->
      cfg_access_done && !we_reg)
      else $error("read word changed outside a read completion");
   AST_READ_SEL: assert property (sReadReq |->
      ##(WAIT_CYCLES + 2) cfg_access_done && !we_reg)
      else $error("read request not completed as a read");
   AST_READ_HOLD: assert property (cfg_access_done && !$past(we_reg) |=> $stable(cfg_read_word))
      else $error("read word changed after done");
   AST_DISABLED: assert property (!CTRL_PORTS_EN |-> !cfg_access_done && !cfg_access_occupied)
      else $error("disabled port shows activity");
   AST_TIE_DEFAULT: assert property (!CTRL_PORTS_EN |-> xcvrCtrlWord == XCVR_CTRL_DEFAULT)
      else $error("disabled control not at default");
   AST_RESET_SYNC: assert property (hardResetIn |-> ##2 hardResetOut)
      else $error("hard reset not passed in two cycles");
   AST_LOCK_SYNC: assert property (!clockStableIn |-> ##2 !clockStableOut ##1 !resetDone)
      else $error("lock loss not forwarded");
   AST_DONE_FALL: assert property (hardResetOut |=> !resetDone)
      else $error("reset done while in hard reset");
   AST_QUARTER: assert property ((NEWER_FAMILY && !CTRL_PORTS_EN) && $rose(stable_clock_quarter_out)
      |-> ##2 $fell(stable_clock_quarter_out))
      else $error("quarter clock period wrong");

endmodule
